// ---- ptc_defs.svh ----
// register offsets, reset values and timing constants of the time counter block
`ifndef PTC_DEFS_SVH
`define PTC_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define PTC_OFF_NS_STEP     20'h12800
`define PTC_OFF_RSVD_GAP    20'h12804
`define PTC_OFF_SEC_LO_STEP 20'h12808
`define PTC_OFF_SEC_HI_STEP 20'h1280c
`define PTC_OFF_INCR        20'h12810
`define PTC_OFF_NS_NOW      20'h12814
`define PTC_OFF_SEC_LO_NOW  20'h12818
`define PTC_OFF_SEC_HI_NOW  20'h1281c
`define PTC_OFF_TIMER_CLR   20'h12820
`define PTC_OFF_PHASE       20'h12824
`define PTC_GRP_LO          20'h12800
`define PTC_GRP_HI          20'h13ffc
`define PTC_OFF_IRQ_STATUS  20'h14000
`define PTC_OFF_IRQ_MASK    20'h14004

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define PTC_FRAC_W          20
`define PTC_IRQ_TIMER       0
`define PTC_IRQ_SEC         1
`define PTC_RST_NS          30'h0
`define PTC_RST_SEC_LO      32'h0
`define PTC_RST_SEC_HI      16'h0
`define PTC_RST_INCR        26'h0
`define PTC_RST_PHASE       30'h0
`define PTC_RST_IRQ         2'h0

// ----------------------------------------------------------------
// timing figures, in nanoseconds of counted time
// ----------------------------------------------------------------
`define PTC_NS_PER_SEC      31'h3b9aca00
`define PTC_TICK_PERIOD_NS  30'h1e848
`define PTC_TICK_HALF_NS    30'hf424

`endif

// ---- ptc_pkg.sv ----
// shared types of the time counter block
package ptc_pkg;
    typedef logic [31:0] ptc_word_t;
    typedef logic [19:0] ptc_addr_t;
    typedef logic [29:0] ptc_ns_t;
    typedef logic [47:0] ptc_sec_t;
    typedef logic [1:0]  ptc_irq_t;
endpackage : ptc_pkg

// ---- ptc_time_counter_regs.sv ----
// precision time counter with step offsets, snapshot reads and an apb slave
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
`include "ptc_defs.svh"

module ptc_time_counter_regs #(
    parameter bit AVB_EN = 1'b1
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire ptc_pkg::ptc_addr_t paddr,
    input  wire ptc_pkg::ptc_word_t pwdata,
    output logic                   pready,
    output ptc_pkg::ptc_word_t     prdata,
    output logic                   pslverr,
    // derived timing and interrupt
    output logic                   derived_eight_khz_tick,
    output logic                   irq
);
    import ptc_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ptc_ns_t     ns_step_q;
    logic [31:0] sec_lo_step_q;
    logic [15:0] sec_hi_step_q;
    logic [25:0] incr_q;
    ptc_ns_t     phase_q;
    ptc_ns_t     ns_int_q;
    logic [`PTC_FRAC_W-1:0] ns_frac_q;
    ptc_sec_t    sec_q;
    ptc_sec_t    cap_sec_q;
    ptc_irq_t    status_q;
    ptc_irq_t    mask_q;
    logic        pready_q;
    ptc_word_t   prdata_q;
    logic        pslverr_q;
    logic        tick_q;
    logic        irq_q;

    // ----------------------------------------------------------------
    // bus phases and decode
    // ----------------------------------------------------------------
    function automatic logic ptc_hit(input ptc_addr_t a, input ptc_addr_t off);
        ptc_hit = AVB_EN && (a == off);
    endfunction : ptc_hit

    logic decide;
    logic commit;
    logic wr;
    logic wr_ns;
    logic rd_ns;
    logic wr_tclr;
    logic in_grp;

    // answer one cycle into the access phase so read data can come from a flop
    assign decide  = psel & penable & ~pready_q;
    assign commit  = psel & penable & pready_q;
    assign wr      = commit & pwrite;
    assign wr_ns   = wr & ptc_hit(paddr, `PTC_OFF_NS_STEP);
    assign rd_ns   = decide & ~pwrite & ptc_hit(paddr, `PTC_OFF_NS_NOW);
    assign wr_tclr = wr & ptc_hit(paddr, `PTC_OFF_TIMER_CLR);
    assign in_grp  = AVB_EN && (paddr >= `PTC_GRP_LO) && (paddr <= `PTC_GRP_HI);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= decide;
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ns_step_q     <= `PTC_RST_NS;
            sec_lo_step_q <= `PTC_RST_SEC_LO;
            sec_hi_step_q <= `PTC_RST_SEC_HI;
            incr_q        <= `PTC_RST_INCR;
            phase_q       <= `PTC_RST_PHASE;
            mask_q        <= `PTC_RST_IRQ;
        end else if (wr) begin
            if (ptc_hit(paddr, `PTC_OFF_NS_STEP)) begin
                ns_step_q <= pwdata[29:0];
            end
            if (ptc_hit(paddr, `PTC_OFF_SEC_LO_STEP)) begin
                sec_lo_step_q <= pwdata;
            end
            if (ptc_hit(paddr, `PTC_OFF_SEC_HI_STEP)) begin
                sec_hi_step_q <= pwdata[15:0];
            end
            if (ptc_hit(paddr, `PTC_OFF_INCR)) begin
                incr_q <= pwdata[25:0];
            end
            if (ptc_hit(paddr, `PTC_OFF_PHASE)) begin
                phase_q <= pwdata[29:0];
            end
            if (paddr == `PTC_OFF_IRQ_MASK) begin
                mask_q <= pwdata[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // time counter
    // ----------------------------------------------------------------
    logic [50:0] sum;
    logic [50:0] sub;
    logic        wrap;

    always_comb begin
        sum  = {1'b0, ns_int_q, ns_frac_q} + {25'h0, incr_q};
        sub  = sum - {`PTC_NS_PER_SEC, 20'h0};
        wrap = sum[50:20] >= `PTC_NS_PER_SEC;
    end

    // the increment tops out near 64 ns, so one subtraction always suffices
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ns_int_q  <= `PTC_RST_NS;
            ns_frac_q <= '0;
            sec_q     <= '0;
        end else if (wr_ns) begin
            ns_int_q  <= pwdata[29:0];
            ns_frac_q <= '0;
            sec_q     <= {sec_hi_step_q, sec_lo_step_q};
        end else if (wrap) begin
            ns_int_q  <= sub[49:20];
            ns_frac_q <= sub[19:0];
            sec_q     <= sec_q + 48'h1;
        end else begin
            ns_int_q  <= sum[49:20];
            ns_frac_q <= sum[19:0];
        end
    end

    // snapshot so the seconds words match the nanoseconds value just read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_sec_q <= '0;
        end else if (rd_ns) begin
            cap_sec_q <= sec_q;
        end
    end

    // ----------------------------------------------------------------
    // phase-shifted 8 khz output
    // ----------------------------------------------------------------
    logic [30:0] psum;
    ptc_ns_t     pwrapped;
    ptc_ns_t     pmod;
    logic        tick_d;

    // constant modulus keeps the divider fixed; costs area, avoids a second counter
    always_comb begin
        psum     = {1'b0, ns_int_q} + {1'b0, phase_q};
        pwrapped = (psum >= `PTC_NS_PER_SEC) ? 30'(psum - `PTC_NS_PER_SEC) : psum[29:0];
        pmod     = pwrapped % `PTC_TICK_PERIOD_NS;
        tick_d   = pmod < `PTC_TICK_HALF_NS;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
        end
    end

    // armed high: the idle level after reset must not look like a rising edge
    logic tick_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_prev_q <= 1'b1;
        end else begin
            tick_prev_q <= tick_d;
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    logic     tick_rise;
    ptc_irq_t ev_set;
    ptc_irq_t ev_clr;

    always_comb begin
        tick_rise = tick_d & ~tick_prev_q;
        ev_set    = '0;
        ev_set[`PTC_IRQ_TIMER] = tick_rise;
        ev_set[`PTC_IRQ_SEC]   = wrap & ~wr_ns;
        ev_clr    = '0;
        if (wr && paddr == `PTC_OFF_IRQ_STATUS) begin
            ev_clr = pwdata[1:0];
        end
        if (wr_tclr) begin
            ev_clr[`PTC_IRQ_TIMER] = 1'b1;
        end
    end

    // set beats clear so an event in the clearing cycle survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= `PTC_RST_IRQ;
            irq_q    <= 1'b0;
        end else begin
            status_q <= (status_q & ~ev_clr) | ev_set;
            irq_q    <= |(status_q & mask_q);
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    ptc_word_t rdata_d;
    logic      err_d;

    always_comb begin
        rdata_d = '0;
        err_d   = 1'b0;
        if (in_grp) begin
            case (paddr)
                `PTC_OFF_NS_STEP:     rdata_d = {2'b00, ns_step_q};
                `PTC_OFF_SEC_LO_STEP: rdata_d = sec_lo_step_q;
                `PTC_OFF_SEC_HI_STEP: rdata_d = {16'h0, sec_hi_step_q};
                `PTC_OFF_INCR:        rdata_d = {6'h0, incr_q};
                `PTC_OFF_NS_NOW:      rdata_d = {2'b00, ns_int_q};
                `PTC_OFF_SEC_LO_NOW:  rdata_d = cap_sec_q[31:0];
                `PTC_OFF_SEC_HI_NOW:  rdata_d = {16'h0, cap_sec_q[47:32]};
                `PTC_OFF_PHASE:       rdata_d = {2'b00, phase_q};
                default:              rdata_d = '0;
            endcase
        end else if (paddr == `PTC_OFF_IRQ_STATUS) begin
            rdata_d = {30'h0, status_q};
        end else if (paddr == `PTC_OFF_IRQ_MASK) begin
            rdata_d = {30'h0, mask_q};
        end else begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= decide & err_d;
            if (decide) begin
                prdata_q <= pwrite ? '0 : rdata_d;
            end
        end
    end

    assign pready                 = pready_q;
    assign prdata                 = prdata_q;
    assign pslverr                = pslverr_q;
    assign derived_eight_khz_tick = tick_q;
    assign irq                    = irq_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [49:0] time_fine;
    ptc_ns_t     step_ns;
    ptc_sec_t    sec_step;
    assign time_fine = {ns_int_q, ns_frac_q};
    assign step_ns   = pwdata[29:0];
    assign sec_step  = {sec_hi_step_q, sec_lo_step_q};

    chk_step_load: assert property (
        wr_ns |=> (ns_int_q == $past(step_ns)) && (sec_q == $past(sec_step)))
        else $error("step offsets not loaded together");

    chk_sec_no_step: assert property (
        wr && paddr == `PTC_OFF_SEC_LO_STEP |=>
            (sec_q == $past(sec_q)) || (sec_q == $past(sec_q) + 48'h1))
        else $error("seconds offset write moved the counter");

    chk_incr_add: assert property (
        !$past(wr_ns) && !$past(wrap) |->
            time_fine == 50'($past(time_fine) + 50'($past(incr_q))))
        else $error("count did not advance by the increment");

    chk_wrap_carry: assert property (
        wrap && !wr_ns |=> (sec_q == $past(sec_q) + 48'h1) && (ns_int_q < $past(ns_int_q)))
        else $error("nanosecond wrap did not carry");

    chk_snap_hold: assert property (
        !rd_ns |=> $stable(cap_sec_q))
        else $error("seconds snapshot changed without a nanoseconds read");

    chk_ns_live: assert property (
        rd_ns |=> pready_q && prdata_q == {2'b00, $past(ns_int_q)} && cap_sec_q == $past(sec_q))
        else $error("nanoseconds read not coherent with snapshot");

    chk_sec_read: assert property (
        decide && !pwrite && ptc_hit(paddr, `PTC_OFF_SEC_LO_NOW) |=> prdata_q == cap_sec_q[31:0])
        else $error("seconds low read not from snapshot");

    chk_rsvd_zero: assert property (
        decide && !pwrite && ptc_hit(paddr, `PTC_OFF_SEC_HI_NOW) |=> prdata_q[31:16] == 16'h0)
        else $error("reserved seconds bits not zero");

    chk_irq_clear: assert property (
        wr_tclr && !tick_rise |=> !status_q[`PTC_IRQ_TIMER] ##1
            (irq_q == ($past(status_q[`PTC_IRQ_SEC]) && $past(mask_q[`PTC_IRQ_SEC]))))
        else $error("timer interrupt not cleared");

    chk_avb_off: assert property (
        !AVB_EN && decide && paddr >= `PTC_GRP_LO && paddr <= `PTC_GRP_HI |=>
            pslverr_q && prdata_q == 32'h0)
        else $error("group answered while not built");

    chk_pready_once: assert property (
        decide |=> pready_q ##1 !pready_q)
        else $error("pready not a single cycle");

    chk_sec_hi_hold: assert property (
        wr && paddr == `PTC_OFF_SEC_HI_STEP |=>
            (sec_q == $past(sec_q)) || (sec_q == $past(sec_q) + 48'h1))
        else $error("seconds high offset write moved the counter");

    chk_rsvd_read: assert property (
        decide && in_grp && (paddr == `PTC_OFF_RSVD_GAP || paddr > `PTC_OFF_PHASE) |=>
            prdata_q == 32'h0 && !pslverr_q)
        else $error("reserved group offset did not read zero");

    chk_clr_reads_zero: assert property (
        decide && !pwrite && ptc_hit(paddr, `PTC_OFF_TIMER_CLR) |=> prdata_q == 32'h0)
        else $error("interrupt clear register did not read zero");

    chk_unmapped_err: assert property (
        decide && !in_grp && paddr != `PTC_OFF_IRQ_STATUS && paddr != `PTC_OFF_IRQ_MASK |=>
            pslverr_q && pready_q && prdata_q == 32'h0)
        else $error("unmapped address not refused");

    chk_set_wins: assert property (
        ev_set != 2'h0 |=> (status_q & $past(ev_set)) == $past(ev_set))
        else $error("interrupt event lost");

    cov_wrap:      cover property (wrap && !wr_ns ##1 status_q[`PTC_IRQ_SEC]);
    cov_step:      cover property (wr && paddr == `PTC_OFF_SEC_LO_STEP ##[1:20] wr_ns);
    cov_tick_irq:  cover property (tick_rise ##[1:4] irq_q);
    cov_snap_read: cover property (rd_ns ##[2:10] decide && paddr == `PTC_OFF_SEC_HI_NOW);
    cov_irq_clear: cover property (irq_q ##1 wr_tclr ##2 !irq_q);

endmodule : ptc_time_counter_regs

// ---- ptc_time_counter_regs_bench.sv ----
// self-checking bench for the time counter register block
`timescale 1ns/100ps
`include "ptc_defs.svh"

module ptc_time_counter_regs_bench;
    import ptc_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic      pclk    = 1'b0;
    logic      presetn = 1'b0;
    logic      psel    = 1'b0;
    logic      penable = 1'b0;
    logic      pwrite  = 1'b0;
    ptc_addr_t paddr   = '0;
    ptc_word_t pwdata  = '0;
    logic      pready;
    ptc_word_t prdata;
    logic      pslverr;
    logic      tick;
    logic      irq;
    int        fail_count = 0;
    int        checked    = 0;
    ptc_word_t rd;
    ptc_word_t k;
    ptc_addr_t rst_a[12] = '{`PTC_OFF_NS_STEP, 20'h12804, `PTC_OFF_SEC_LO_STEP, 20'h13ffc,
                             `PTC_OFF_SEC_HI_STEP, `PTC_OFF_INCR, `PTC_OFF_NS_NOW,
                             `PTC_OFF_SEC_LO_NOW, `PTC_OFF_SEC_HI_NOW, `PTC_OFF_TIMER_CLR,
                             `PTC_OFF_PHASE, `PTC_OFF_IRQ_MASK};
    ptc_addr_t rw_a[4]  = '{`PTC_OFF_SEC_LO_STEP, `PTC_OFF_SEC_HI_STEP, `PTC_OFF_INCR,
                            `PTC_OFF_PHASE};
    ptc_word_t rw_e[4]  = '{32'hffffffff, 32'h0000ffff, 32'h03ffffff, 32'h3fffffff};

    always #10 pclk = ~pclk;

    ptc_time_counter_regs u_ptc_time_counter_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .derived_eight_khz_tick(tick), .irq(irq));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input ptc_word_t got, input ptc_word_t exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // starts on a fresh edge so a release is never overwritten in one time step
    task automatic xfer(input logic wr, input ptc_addr_t a, input ptc_word_t d, input logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        chk({31'h0, pready}, 32'h1);
        chk({31'h0, pslverr}, {31'h0, err});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input ptc_addr_t a, input ptc_word_t d);
        xfer(1'b1, a, d, 1'b0);
    endtask : wr

    task automatic rdc(input ptc_addr_t a, input ptc_word_t exp);
        xfer(1'b0, a, 32'h0, 1'b0);
        chk(rd, exp);
    endtask : rdc

    // ----------------------------------------------------------------
    // watchdog
    // ----------------------------------------------------------------
    initial begin
        #(20 * 20000);
        fail_count++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rst_a[i]) rdc(rst_a[i], 32'h0);
        xfer(1'b0, 20'h00000, 32'h0, 1'b1);
        chk(rd, 32'h0);
        xfer(1'b1, 20'h10000, 32'hffffffff, 1'b1);
        foreach (rw_a[i]) begin
            wr(rw_a[i], 32'hffffffff);
            rdc(rw_a[i], rw_e[i]);
        end
        wr(`PTC_OFF_INCR, 32'h0);
        wr(`PTC_OFF_PHASE, 32'h0);
        wr(`PTC_OFF_NS_STEP, 32'hc0000005);
        rdc(`PTC_OFF_NS_STEP, 32'h00000005);
        wr(20'h12804, 32'hffffffff);
        rdc(20'h12804, 32'h0);
        wr(`PTC_OFF_NS_NOW, 32'h0000abcd);
        // stopped counter: load visible exactly, seconds taken with the step
        rdc(`PTC_OFF_NS_NOW, 32'h5);
        rdc(`PTC_OFF_SEC_LO_NOW, 32'hffffffff);
        rdc(`PTC_OFF_SEC_HI_NOW, 32'h0000ffff);
        wr(`PTC_OFF_SEC_LO_STEP, 32'h11);
        rdc(`PTC_OFF_NS_NOW, 32'h5);
        rdc(`PTC_OFF_SEC_LO_NOW, 32'hffffffff);
        // 1.25 ns per clock; reads four clocks apart differ by five
        wr(`PTC_OFF_INCR, 32'h00140000);
        xfer(1'b0, `PTC_OFF_NS_NOW, 32'h0, 1'b0);
        k = rd;
        rdc(`PTC_OFF_NS_NOW, k + 32'd5);
        // load-to-read lag measured at 1 ns per clock, then reused across the carry
        wr(`PTC_OFF_INCR, 32'h00100000);
        wr(`PTC_OFF_NS_STEP, 32'd100);
        xfer(1'b0, `PTC_OFF_NS_NOW, 32'h0, 1'b0);
        k = rd - 32'd100;
        wr(`PTC_OFF_SEC_LO_STEP, 32'hffffffff);
        wr(`PTC_OFF_SEC_HI_STEP, 32'h1);
        wr(`PTC_OFF_NS_STEP, 32'd999999999);
        rdc(`PTC_OFF_NS_NOW, k - 32'd1);
        rdc(`PTC_OFF_SEC_LO_NOW, 32'h0);
        rdc(`PTC_OFF_SEC_HI_NOW, 32'h2);
        xfer(1'b0, `PTC_OFF_IRQ_STATUS, 32'h0, 1'b0);
        chk(rd & 32'h2, 32'h2);
        wr(`PTC_OFF_SEC_LO_STEP, 32'h7);
        wr(`PTC_OFF_SEC_HI_STEP, 32'h0);
        wr(`PTC_OFF_NS_STEP, 32'h0);
        rdc(`PTC_OFF_SEC_LO_NOW, 32'h0);
        xfer(1'b0, `PTC_OFF_NS_NOW, 32'h0, 1'b0);
        rdc(`PTC_OFF_SEC_LO_NOW, 32'h7);
        // frozen counter at zero so the tick only moves with the phase
        wr(`PTC_OFF_INCR, 32'h0);
        wr(`PTC_OFF_NS_STEP, 32'h0);
        wr(`PTC_OFF_IRQ_STATUS, 32'h3);
        rdc(`PTC_OFF_IRQ_STATUS, 32'h0);
        chk({31'h0, tick}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(`PTC_OFF_PHASE, 32'd62500);
        rdc(`PTC_OFF_PHASE, 32'd62500);
        chk({31'h0, tick}, 32'h0);
        wr(`PTC_OFF_PHASE, 32'h0);
        rdc(`PTC_OFF_PHASE, 32'h0);
        chk({31'h0, tick}, 32'h1);
        rdc(`PTC_OFF_IRQ_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(`PTC_OFF_IRQ_MASK, 32'h1);
        rdc(`PTC_OFF_IRQ_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(`PTC_OFF_TIMER_CLR, 32'h0);
        rdc(`PTC_OFF_IRQ_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        end_sim();
    end
endmodule : ptc_time_counter_regs_bench
